// >>> design/ssta_pkg.sv
// Purpose: shared constants and types for the status telegram assembler
// Assumes: 32-bit APB, telegram bytes 4..15 carried MSB-first per word
// Notes: byte n of a word sits in bits 31:24, byte n+3 in bits 7:0
package ssta_pkg;
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h04;
	localparam logic [7:0]  OFS_IRQ_MASK    = 8'h08;
	localparam logic [7:0]  OFS_TEL_IO      = 8'h0C;
	localparam logic [7:0]  OFS_TEL_SCAN    = 8'h10;
	localparam logic [7:0]  OFS_TEL_FUNC_A  = 8'h14;

	localparam int unsigned CTRL_CAPTURE_EN = 0;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

	localparam int unsigned IRQ_W           = 2;
	localparam int unsigned IRQ_TEL_READY   = 0;
	localparam int unsigned IRQ_SCAN_WRAP   = 1;
	localparam logic [1:0]  IRQ_MASK_RESET  = 2'h0;

	localparam logic [31:0] SCAN_RESET      = 32'h0000_0000;
	localparam logic [31:0] SCAN_MAX        = 32'hFFFF_FFFF;
	localparam logic [3:0]  SEL_RESET       = 4'h0;

	// live function A status, sampled once per completed scan
	typedef struct packed {
		logic       active;
		logic       warn_zone_state;
		logic       guard_zone_state;
		logic       restart_lock;
		logic       switch_out;
		logic [3:0] bank_sel;
		logic [3:0] pair_sel_one;
		logic [3:0] pair_sel_two;
		logic [3:0] pair_sel_three;
		logic       warn_segment_one;
		logic       warn_segment_two;
		logic       guard_segment_one;
		logic       guard_segment_two;
		logic       pair_match_one;
		logic       pair_match_two;
	} ssta_func_a_t;

	// live pin states of the scanner
	typedef struct packed {
		logic [9:0] control_in;
		logic       start_in_func_a;
		logic       start_in_func_b;
		logic       feedback_in_func_a;
		logic       feedback_in_func_b;
		logic [1:0] feedback_in_aux;
		logic       linkage_in_one;
		logic       linkage_in_two;
		logic       input_pnp;
		logic [3:0] general_out;
		logic       signal_output;
	} ssta_pins_t;

	// telegram bytes 4..15
	typedef struct packed {
		logic [7:0]  byte4;
		logic [7:0]  byte5;
		logic [7:0]  byte6;
		logic [7:0]  byte7;
		logic [31:0] scan_count;
		logic [7:0]  byte12;
		logic [7:0]  byte13;
		logic [7:0]  byte14;
		logic [7:0]  byte15;
	} ssta_telegram_t;

	localparam ssta_telegram_t TEL_RESET = '0;
endpackage : ssta_pkg

// >>> design/ssta_top.sv
// Purpose: assembles status telegram bytes 4..15 once per completed scan
// Assumes: all inputs synchronous to i_ref_clk, i_scan_done one-cycle pulse
// Notes: telegram also readable over APB, one wait state per transfer
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ssta_top (
	input  wire logic                  i_ref_clk,    // 25 MHz clock
	input  wire logic                  i_reset,      // async, active high
	input  wire logic                  i_scan_done,  // pulse per completed scan
	input  wire ssta_pkg::ssta_pins_t  i_pins,       // live pin states
	input  wire ssta_pkg::ssta_func_a_t i_func_a,    // live function A status
	input  wire logic                  i_psel,       // apb select
	input  wire logic                  i_penable,    // apb enable
	input  wire logic                  i_pwrite,     // apb direction
	input  wire logic [7:0]            i_paddr,      // apb byte address
	input  wire logic [31:0]           i_pwdata,     // apb write data
	output logic [31:0]                o_prdata,     // apb read data
	output logic                       o_pready,     // apb ready
	output logic                       o_pslverr,    // apb error, unmapped
	output logic                       o_irq,        // level interrupt
	output ssta_pkg::ssta_telegram_t   o_telegram,   // assembled bytes 4..15
	output logic                       o_telegram_valid // pulse, new telegram
);
	ssta_pkg::ssta_telegram_t tel_reg,     tel_next;
	logic                     tel_vld_reg, tel_vld_next;
	logic [31:0]              scan_reg,    scan_next;
	logic [31:0]              ctrl_reg,    ctrl_next;
	logic [1:0]               stat_reg,    stat_next;
	logic [1:0]               mask_reg,    mask_next;
	logic                     irq_reg,     irq_next;
	logic [31:0]              rdata_reg,   rdata_next;
	logic                     ready_reg,   ready_next;
	logic                     err_reg,     err_next;
	ssta_pkg::ssta_telegram_t snap;
	logic                     access;
	logic                     wr_done;
	logic                     mapped;
	logic [1:0]               events;

	// telegram image of the live inputs
	always_comb begin
		snap = ssta_pkg::TEL_RESET;
		for (int k = 0; k < 8; k++) begin
			snap.byte4[7-k] = i_pins.control_in[k];
		end
		snap.byte5 = {i_pins.control_in[8], i_pins.control_in[9],
			i_pins.start_in_func_a, i_pins.start_in_func_b,
			i_pins.feedback_in_func_a, i_pins.feedback_in_func_b,
			i_pins.feedback_in_aux[0], i_pins.feedback_in_aux[1]};
		snap.byte6 = {i_pins.linkage_in_one, i_pins.linkage_in_two, i_pins.input_pnp,
			i_pins.general_out[0], i_pins.general_out[1], i_pins.general_out[2],
			i_pins.general_out[3], i_pins.signal_output};
		snap.byte7 = 8'h00;
		snap.scan_count = scan_reg + 32'h0000_0001;
		snap.byte12[7] = i_func_a.active;
		snap.byte12[6] = i_func_a.warn_zone_state;
		snap.byte12[5] = i_func_a.guard_zone_state;
		snap.byte12[4] = i_func_a.restart_lock;
		snap.byte12[3] = i_func_a.switch_out;
		snap.byte12[2:0] = 3'h0;
		snap.byte13 = {i_func_a.bank_sel, i_func_a.pair_sel_one};
		snap.byte14[7:4] = i_func_a.pair_sel_two;
		snap.byte14[3:0] = i_func_a.pair_sel_three;
		snap.byte15[7:4] = {i_func_a.warn_segment_one, i_func_a.warn_segment_two,
			i_func_a.guard_segment_one, i_func_a.guard_segment_two};
		snap.byte15[3:2] = {i_func_a.pair_match_one, i_func_a.pair_match_two};
		snap.byte15[1:0] = 2'h0;
	end

	// scan counter and telegram capture
	always_comb begin
		scan_next    = scan_reg;
		tel_next     = tel_reg;
		tel_vld_next = 1'b0;
		events       = 2'h0;
		if (i_scan_done) begin
			scan_next = scan_reg + 32'h0000_0001;
			events[ssta_pkg::IRQ_SCAN_WRAP] = (scan_reg == ssta_pkg::SCAN_MAX);
			if (ctrl_reg[ssta_pkg::CTRL_CAPTURE_EN]) begin
				tel_next     = snap;
				tel_vld_next = 1'b1;
				events[ssta_pkg::IRQ_TEL_READY] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			scan_reg    <= ssta_pkg::SCAN_RESET;
			tel_reg     <= ssta_pkg::TEL_RESET;
			tel_vld_reg <= 1'b0;
		end else begin
			scan_reg    <= scan_next;
			tel_reg     <= tel_next;
			tel_vld_reg <= tel_vld_next;
		end
	end

	// apb slave, one wait state
	assign access  = i_psel && i_penable && !ready_reg;
	assign wr_done = i_psel && i_penable && ready_reg && i_pwrite;

	always_comb begin
		case (i_paddr)
			ssta_pkg::OFS_CTRL,
			ssta_pkg::OFS_IRQ_STATUS,
			ssta_pkg::OFS_IRQ_MASK,
			ssta_pkg::OFS_TEL_IO,
			ssta_pkg::OFS_TEL_SCAN,
			ssta_pkg::OFS_TEL_FUNC_A: mapped = 1'b1;
			default:                  mapped = 1'b0;
		endcase
	end

	always_comb begin
		ready_next = access;
		err_next   = access && !mapped;
		rdata_next = 32'h0000_0000;
		if (access && !i_pwrite) begin
			case (i_paddr)
				ssta_pkg::OFS_CTRL:       rdata_next = ctrl_reg;
				ssta_pkg::OFS_IRQ_STATUS: rdata_next = {30'h0, stat_reg};
				ssta_pkg::OFS_IRQ_MASK:   rdata_next = {30'h0, mask_reg};
				ssta_pkg::OFS_TEL_IO:     rdata_next = {tel_reg.byte4, tel_reg.byte5,
				                                        tel_reg.byte6, tel_reg.byte7};
				ssta_pkg::OFS_TEL_SCAN:   rdata_next = tel_reg.scan_count;
				ssta_pkg::OFS_TEL_FUNC_A: rdata_next = {tel_reg.byte12, tel_reg.byte13,
				                                        tel_reg.byte14, tel_reg.byte15};
				default:                  rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// control, sticky status with write-one-clear, mask
	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		if (wr_done && i_paddr == ssta_pkg::OFS_CTRL) begin
			ctrl_next = {31'h0, i_pwdata[ssta_pkg::CTRL_CAPTURE_EN]};
		end
		if (wr_done && i_paddr == ssta_pkg::OFS_IRQ_MASK) begin
			mask_next = i_pwdata[1:0];
		end
		if (wr_done && i_paddr == ssta_pkg::OFS_IRQ_STATUS) begin
			stat_next = stat_reg & ~i_pwdata[1:0];
		end
		stat_next = stat_next | events;
		irq_next  = |(stat_next & mask_next);
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			ctrl_reg  <= ssta_pkg::CTRL_RESET;
			mask_reg  <= ssta_pkg::IRQ_MASK_RESET;
			stat_reg  <= 2'h0;
			irq_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
			err_reg   <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			mask_reg  <= mask_next;
			stat_reg  <= stat_next;
			irq_reg   <= irq_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg   <= err_next;
		end
	end

	assign o_prdata         = rdata_reg;
	assign o_pready         = ready_reg;
	assign o_pslverr        = err_reg;
	assign o_irq            = irq_reg;
	assign o_telegram       = tel_reg;
	assign o_telegram_valid = tel_vld_reg;
endmodule : ssta_top

// >>> tb/ssta_checker.sv
// Purpose: port-level assertions for the telegram assembler
// Assumes: one clock domain, async high reset
// Notes: bound into ssta_top
`timescale 1ns/1ps
module ssta_checker (
	input wire logic                   i_ref_clk,       // clock
	input wire logic                   i_reset,         // reset
	input wire logic                   i_scan_done,     // scan pulse
	input wire ssta_pkg::ssta_pins_t   i_pins,          // pin states
	input wire ssta_pkg::ssta_func_a_t i_func_a,        // function A status
	input wire ssta_pkg::ssta_telegram_t o_telegram,    // telegram
	input wire logic                   o_telegram_valid // capture pulse
);
	ssta_pkg::ssta_func_a_t f_q;
	ssta_pkg::ssta_pins_t   p_q;
	always_ff @(posedge i_ref_clk) begin
		f_q <= i_func_a;
		p_q <= i_pins;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	a_valid_cause: assert property (o_telegram_valid |-> $past(i_scan_done)) else $error("valid without scan");
	a_count_step: assert property (o_telegram_valid && $past(o_telegram_valid)
		|-> o_telegram.scan_count == $past(o_telegram.scan_count) + 32'h1) else $error("count step");
	a_count_start: assert property ($fell(i_reset) |-> o_telegram.scan_count == 32'h0) else $error("count start");
	a_byte12_map: assert property (o_telegram_valid |-> o_telegram.byte12[7:3] == {f_q.active,
		f_q.warn_zone_state, f_q.guard_zone_state, f_q.restart_lock, f_q.switch_out}) else $error("byte12");
	a_byte13_map: assert property (o_telegram_valid |-> o_telegram.byte13 == {f_q.bank_sel, f_q.pair_sel_one})
		else $error("byte13");
	a_byte14_map: assert property (o_telegram_valid |-> o_telegram.byte14 == {f_q.pair_sel_two, f_q.pair_sel_three})
		else $error("byte14");
	a_byte15_map: assert property (o_telegram_valid |-> o_telegram.byte15[7:2] == {f_q.warn_segment_one,
		f_q.warn_segment_two, f_q.guard_segment_one, f_q.guard_segment_two, f_q.pair_match_one,
		f_q.pair_match_two}) else $error("byte15");
	a_byte6_map: assert property (o_telegram_valid |-> o_telegram.byte6 == {p_q.linkage_in_one, p_q.linkage_in_two,
		p_q.input_pnp, p_q.general_out[0], p_q.general_out[1], p_q.general_out[2], p_q.general_out[3],
		p_q.signal_output}) else $error("byte6");
	a_reserved_zero: assert property (o_telegram.byte7 == 8'h00 && o_telegram.byte12[2:0] == 3'h0
		&& o_telegram.byte15[1:0] == 2'h0) else $error("reserved bits");
	a_hold_between: assert property (!o_telegram_valid |-> $stable(o_telegram)) else $error("telegram moved");
endmodule : ssta_checker
bind ssta_top ssta_checker u_chk (.i_ref_clk, .i_reset, .i_scan_done, .i_pins, .i_func_a, .o_telegram,
	.o_telegram_valid);

// >>> tb/ssta_host_model.sv
// Purpose: receiver of assembled telegrams
// Assumes: takes a telegram on each valid pulse
// Notes: keeps last telegram and a count
`timescale 1ns/1ps
module ssta_host_model (
	input wire logic                     i_ref_clk,  // clock
	input wire logic                     i_reset,    // reset
	input wire logic                     i_valid,    // capture pulse
	input wire ssta_pkg::ssta_telegram_t i_telegram, // telegram
	output ssta_pkg::ssta_telegram_t     o_last,     // last received
	output logic [15:0]                  o_count     // telegrams seen
);
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_last  <= '0;
			o_count <= 16'h0000;
		end else if (i_valid) begin
			o_last  <= i_telegram;
			o_count <= o_count + 16'h0001;
		end
	end
endmodule : ssta_host_model

// >>> tb/ssta_top_tb.sv
// Purpose: self-checking bench for the telegram assembler
// Assumes: APB answers within 20 cycles
// Notes: expectations built from pin and status fields
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; $display("FAIL %s exp %h got %h", n, e, s); end end
module ssta_top_tb;
	logic clk = 1'b0, rst = 1'b1, scan = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err, irq, pready, slverr, valid;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0, rd, cnt, prdata;
	logic [15:0] hcnt;
	int err_count = 0, comparisons = 0;
	ssta_pkg::ssta_pins_t pins = '0;
	ssta_pkg::ssta_func_a_t fa = '0;
	ssta_pkg::ssta_telegram_t tel, exp, hlast;
	always #20 clk = ~clk;
	ssta_top DUT (.i_ref_clk(clk), .i_reset(rst), .i_scan_done(scan), .i_pins(pins), .i_func_a(fa), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(slverr), .o_irq(irq), .o_telegram(tel), .o_telegram_valid(valid));
	ssta_host_model u_host (.i_ref_clk(clk), .i_reset(rst), .i_valid(valid), .i_telegram(tel), .o_last(hlast),
		.o_count(hcnt));
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk) begin psel <= 1'b1; pwr <= w; addr <= a; wd <= d; end
		@(posedge clk) pen <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) err_count++;
		rd = prdata;
		err = slverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task scan_run(input int k, input logic cap);
		@(posedge clk) scan <= 1'b1;
		repeat (k) @(posedge clk);
		scan <= 1'b0;
		cnt = cnt + k;
		@(posedge clk);
		if (cap) begin
			exp = '0;
			for (int i = 0; i < 8; i++) exp.byte4[7-i] = pins.control_in[i];
			exp.byte5 = {pins.control_in[8], pins.control_in[9], pins.start_in_func_a, pins.start_in_func_b,
				pins.feedback_in_func_a,
				pins.feedback_in_func_b, pins.feedback_in_aux[0], pins.feedback_in_aux[1]};
			exp.byte6 = {pins.linkage_in_one, pins.linkage_in_two, pins.input_pnp, pins.general_out[0],
				pins.general_out[1], pins.general_out[2], pins.general_out[3], pins.signal_output};
			exp.scan_count = cnt;
			exp.byte12 = {fa.active, fa.warn_zone_state, fa.guard_zone_state, fa.restart_lock, fa.switch_out, 3'h0};
			exp.byte13 = {fa.bank_sel, fa.pair_sel_one};
			exp.byte14 = {fa.pair_sel_two, fa.pair_sel_three};
			exp.byte15 = {fa.warn_segment_one, fa.warn_segment_two, fa.guard_segment_one, fa.guard_segment_two,
				fa.pair_match_one, fa.pair_match_two, 2'h0};
		end
		`CHK("valid", cap, valid)
		`CHK("telegram", exp, tel)
	endtask : scan_run
	task summarize;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		#(40 * 20000);
		err_count++;
		summarize;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		cnt = 0;
		exp = '0;
		`CHK("reset telegram", exp, tel)
		apb(1'b1, ssta_pkg::OFS_IRQ_MASK, 32'h1);
		for (int i = 0; i < 2; i++) begin
			pins <= (i == 0) ? 24'hA5C396 : 24'h5A3C69;
			fa <= (i == 0) ? 27'h5A3CE71 : 27'h2A5C318;
			scan_run(1, 1'b1);
		end
		apb(1'b0, ssta_pkg::OFS_TEL_FUNC_A, 32'h0);
		`CHK("func word", {exp.byte12, exp.byte13, exp.byte14, exp.byte15}, rd)
		apb(1'b0, ssta_pkg::OFS_IRQ_STATUS, 32'h0);
		`CHK("irq set", 2'b11, {irq, rd[0]})
		apb(1'b1, ssta_pkg::OFS_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		`CHK("irq clear", 1'b0, irq)
		scan_run(3, 1'b1);
		apb(1'b1, ssta_pkg::OFS_CTRL, 32'h0);
		scan_run(1, 1'b0);
		apb(1'b1, ssta_pkg::OFS_CTRL, 32'h1);
		scan_run(1, 1'b1);
		apb(1'b0, ssta_pkg::OFS_TEL_SCAN, 32'h0);
		`CHK("scan word", cnt, rd)
		apb(1'b0, 8'hFC, 32'h0);
		`CHK("unmapped", 33'h100000000, {err, rd})
		`CHK("host count", 16'h0006, hcnt)
		`CHK("host last", exp, hlast)
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		cnt = 0;
		scan_run(1, 1'b1);
		summarize;
	end
endmodule : ssta_top_tb
